// ---- hdl/dnb_regs.svh ----
/*
  constants for the diagnostic interrupt and beep code block.
  assumes inclusion by bare name from the design files.
*/
// Function
// - diagnostic interrupt pulse stays asserted at least 30 ms.
// - one pulse only until system reset or power-down rearms it.
// - chassis control request triggers the pulse, subject to lockout.
// - chassis control pulse logs no event.
// - front panel button triggers the pulse and logs a sensor event.
// - watchdog pre-timeout triggers pulse, no log, only if action configured.
// - beep code plays once per failure discovery, never repeats alone.
// - each digit sounds as that many beeps, digits in order.
// - no processor plays 1-5-2-1; model identifier mismatch plays 1-5-2-4.
// - power good dropout plays 1-5-4-2.
// - power good assertion timeout plays 1-5-4-4.
// - voltage regulator watchdog sensor assertion plays 1-5-1-2.
// - incompatible supply with power failure plays 1-5-1-4.
// - probe key module at init; enable advanced features only on success.
`ifndef DNB_REGS_SVH
`define DNB_REGS_SVH
`define DNB_CLK_HZ        200000000
`define DNB_NMI_MS        30
`define DNB_TICK_DIV      200000
`define DNB_BEEP_ON_T     100
`define DNB_BEEP_GAP_T    100
`define DNB_DIGIT_GAP_T   500
`define DNB_CODE_NOCPU    16'h1521
`define DNB_CODE_MODEL    16'h1524
`define DNB_CODE_PGDROP   16'h1542
`define DNB_CODE_PGTMO    16'h1544
`define DNB_CODE_VRWD     16'h1512
`define DNB_CODE_PSU      16'h1514
`define DNB_NCAUSE        6
`define DNB_PROBE_TMO     1000
`endif

// ---- hdl/dnb_pkg.sv ----
/*
  types shared by the block.
  assumes nothing outside.
*/
package dnb_pkg;
  typedef enum logic [2:0] {
    BP_IDLE  = 3'b000,
    BP_LOAD  = 3'b001,
    BP_ON    = 3'b010,
    BP_GAP   = 3'b011,
    BP_DGAP  = 3'b100
  } dnb_beep_t;
  typedef enum logic [1:0] {
    KP_REQ  = 2'b00,
    KP_WAIT = 2'b01,
    KP_DONE = 2'b10
  } dnb_probe_t;
endpackage

// ---- hdl/dnb_beeper.sv ----
/*
  beep sequencer: plays one four digit code, digits as beep groups.
  assumes a one-cycle tick enable from the management time base.
*/
`timescale 1ns/100ps
`include "dnb_regs.svh"
module dnb_beeper #(
  parameter int TW = 16
) (
  // clock and reset
  input  wire logic          clock_i,
  input  wire logic          srst_i,
  input  wire logic          tick_i,
  // timing
  input  wire logic [TW-1:0] on_t_i,
  input  wire logic [TW-1:0] gap_t_i,
  input  wire logic [TW-1:0] dgap_t_i,
  // request
  input  wire logic          start_i,
  input  wire logic [15:0]   code_i,
  // outputs
  output logic               beep_o,
  output logic               busy_o
);
  dnb_pkg::dnb_beep_t state;
  logic [15:0]   code;
  logic [1:0]    digit;
  logic [3:0]    left;
  logic [TW-1:0] cnt;
  wire           done = (cnt == '0);
  wire  [3:0]    cur  = code[15:12];
  wire  [TW-1:0] cnt_dec = cnt - TW'(1);

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state  <= dnb_pkg::BP_IDLE;
      code   <= '0;
      digit  <= '0;
      left   <= '0;
      cnt    <= '0;
      beep_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      case (state)
        dnb_pkg::BP_IDLE: begin
          beep_o <= 1'b0;
          busy_o <= start_i;
          if (start_i) begin
            code  <= code_i;
            digit <= '0;
            state <= dnb_pkg::BP_LOAD;
          end
        end
        dnb_pkg::BP_LOAD: begin
          left   <= cur - 4'h1;
          cnt    <= on_t_i;
          beep_o <= (cur != 4'h0);
          state  <= dnb_pkg::BP_ON;
        end
        dnb_pkg::BP_ON: if (tick_i) begin
          if (!done) begin
            cnt <= cnt_dec;
          end else begin
            beep_o <= 1'b0;
            if (left != 4'h0 && cur != 4'h0) begin
              cnt   <= gap_t_i;
              state <= dnb_pkg::BP_GAP;
            end else begin
              cnt   <= dgap_t_i;
              state <= dnb_pkg::BP_DGAP;
            end
          end
        end
        dnb_pkg::BP_GAP: if (tick_i) begin
          if (!done) begin
            cnt <= cnt_dec;
          end else begin
            left   <= left - 4'h1;
            cnt    <= on_t_i;
            beep_o <= 1'b1;
            state  <= dnb_pkg::BP_ON;
          end
        end
        dnb_pkg::BP_DGAP: if (tick_i) begin
          if (!done) begin
            cnt <= cnt_dec;
          end else if (digit == 2'd3) begin
            busy_o <= 1'b0;
            state  <= dnb_pkg::BP_IDLE;
          end else begin
            digit <= digit + 2'd1;
            code  <= {code[11:0], 4'h0};
            state <= dnb_pkg::BP_LOAD;
          end
        end
        default: state <= dnb_pkg::BP_IDLE;
      endcase
    end
  end

  property p_beep_idle;
    @(posedge clock_i) disable iff (srst_i)
      (state == dnb_pkg::BP_IDLE && !start_i) |=> !beep_o;
  endproperty
  a_beep_idle: assert property (p_beep_idle)
    else $error("beep sounded while idle");

  property p_beep_gap_silent;
    @(posedge clock_i) disable iff (srst_i)
      (state == dnb_pkg::BP_GAP || state == dnb_pkg::BP_DGAP) |-> !beep_o;
  endproperty
  a_beep_gap_silent: assert property (p_beep_gap_silent)
    else $error("beep sounded in a gap");
endmodule // dnb_beeper

// ---- hdl/dnb_diag.sv ----
/*
  diagnostic interrupt pulse generator, beep code trigger, event logging
  strobe and key module probe.
  assumes inputs synchronous to clock_i; request inputs are one-cycle
  pulses; failure inputs are levels whose rising edge is a discovery.
*/
`timescale 1ns/100ps
`include "dnb_regs.svh"
module dnb_diag #(
  parameter int CLK_HZ    = `DNB_CLK_HZ,
  parameter int NMI_MS    = `DNB_NMI_MS,
  parameter int TICK_DIV  = `DNB_TICK_DIV,
  parameter int PROBE_TMO = `DNB_PROBE_TMO,
  parameter int TW        = 16
) (
  // clock and reset
  input  wire logic          clock_i,
  input  wire logic          srst_i,
  // interrupt sources
  input  wire logic          chassis_req_i,
  input  wire logic          panel_button_i,
  input  wire logic          wd_pretimeout_i,
  input  wire logic          wd_action_diag_i,
  // rearm
  input  wire logic          sys_reset_i,
  input  wire logic          power_down_i,
  // failure conditions
  input  wire logic          no_cpu_i,
  input  wire logic          processor_model_identifier_bad_i,
  input  wire logic          pgood_dropout_i,
  input  wire logic          pgood_timeout_i,
  input  wire logic          voltage_regulator_wd_i,
  input  wire logic          psu_incompat_fail_i,
  // beep timing in ticks
  input  wire logic [TW-1:0] beep_on_t_i,
  input  wire logic [TW-1:0] beep_gap_t_i,
  input  wire logic [TW-1:0] digit_gap_t_i,
  // key module probe
  input  wire logic          key_ack_i,
  output logic               key_probe_o,
  output logic               advanced_en_o,
  // outputs
  output logic               nmi_o,
  output logic               panel_event_o,
  output logic               beep_o,
  output logic               beep_busy_o
);
  localparam longint NMI_CYC = longint'(CLK_HZ) / 1000 * NMI_MS;
  localparam int     NW      = $clog2(NMI_CYC + 1);
  localparam int     DW      = $clog2(TICK_DIV);
  localparam int     PW      = $clog2(PROBE_TMO + 1);
  localparam int     NC      = `DNB_NCAUSE;

  // one-shot interrupt pulse
  logic          nmi_locked;
  logic [NW-1:0] nmi_cnt;
  wire  wd_hit   = wd_pretimeout_i && wd_action_diag_i;
  wire  trig     = chassis_req_i || panel_button_i || wd_hit;
  wire  rearm    = sys_reset_i || power_down_i;
  wire  fire     = trig && !nmi_locked && !nmi_o && !rearm;
  wire  nmi_end  = nmi_o && (nmi_cnt == NW'(NMI_CYC - 1));

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      nmi_o      <= 1'b0;
      nmi_cnt    <= '0;
      nmi_locked <= 1'b0;
    end else begin
      if (fire) begin
        nmi_o   <= 1'b1;
        nmi_cnt <= '0;
      end else if (nmi_end) begin
        nmi_o <= 1'b0;
      end else if (nmi_o) begin
        nmi_cnt <= nmi_cnt + NW'(1);
      end
      if (fire) begin
        nmi_locked <= 1'b1;
      end else if (rearm && !nmi_o) begin
        nmi_locked <= 1'b0;
      end
    end
  end

  // only the panel button logs, on every press, whether or not it produced the pulse
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      panel_event_o <= 1'b0;
    end else begin
      panel_event_o <= panel_button_i;
    end
  end

  // management time base
  logic [DW-1:0] div;
  logic          tick;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      div  <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (div == DW'(TICK_DIV - 1));
      div  <= (div == DW'(TICK_DIV - 1)) ? '0 : div + DW'(1);
    end
  end

  // failure discovery: rising edges latched as pending codes
  wire  [NC-1:0] cond = {psu_incompat_fail_i, voltage_regulator_wd_i,
                         pgood_timeout_i, pgood_dropout_i,
                         processor_model_identifier_bad_i, no_cpu_i};
  logic [NC-1:0] cond_q;
  logic [NC-1:0] pend;
  logic          start;
  logic [15:0]   code;
  wire  [NC-1:0] rise = cond & ~cond_q;
  wire  [NC-1:0] take = pend & (~pend + NC'(1));

  function automatic logic [15:0] code_of(input logic [NC-1:0] one);
    logic [15:0] c;
    c = `DNB_CODE_NOCPU;
    if (one[1]) c = `DNB_CODE_MODEL;
    if (one[2]) c = `DNB_CODE_PGDROP;
    if (one[3]) c = `DNB_CODE_PGTMO;
    if (one[4]) c = `DNB_CODE_VRWD;
    if (one[5]) c = `DNB_CODE_PSU;
    return c;
  endfunction

  wire go = (pend != '0) && !beep_busy_o && !start;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cond_q <= '0;
      pend   <= '0;
      start  <= 1'b0;
      code   <= '0;
    end else begin
      cond_q <= cond;
      start  <= go;
      if (go) begin
        code <= code_of(take);
      end
      pend <= (pend & ~(go ? take : '0)) | rise;
    end
  end

  dnb_beeper #(.TW(TW)) u_beeper (
    .clock_i  (clock_i),
    .srst_i   (srst_i),
    .tick_i   (tick),
    .on_t_i   (beep_on_t_i),
    .gap_t_i  (beep_gap_t_i),
    .dgap_t_i (digit_gap_t_i),
    .start_i  (start),
    .code_i   (code),
    .beep_o   (beep_o),
    .busy_o   (beep_busy_o)
  );

  // key module probe at initialisation
  dnb_pkg::dnb_probe_t pst;
  logic [PW-1:0] pcnt;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pst           <= dnb_pkg::KP_REQ;
      pcnt          <= '0;
      key_probe_o   <= 1'b0;
      advanced_en_o <= 1'b0;
    end else begin
      case (pst)
        dnb_pkg::KP_REQ: begin
          key_probe_o <= 1'b1;
          pst         <= dnb_pkg::KP_WAIT;
        end
        dnb_pkg::KP_WAIT: begin
          pcnt <= pcnt + PW'(1);
          if (key_ack_i) begin
            advanced_en_o <= 1'b1;
            key_probe_o   <= 1'b0;
            pst           <= dnb_pkg::KP_DONE;
          end else if (pcnt == PW'(PROBE_TMO)) begin
            key_probe_o <= 1'b0;
            pst         <= dnb_pkg::KP_DONE;
          end
        end
        dnb_pkg::KP_DONE: key_probe_o <= 1'b0;
        default: pst <= dnb_pkg::KP_REQ;
      endcase
    end
  end

  property p_nmi_min;
    @(posedge clock_i) disable iff (srst_i)
      $rose(nmi_o) |-> nmi_o [*8];
  endproperty
  a_nmi_min: assert property (p_nmi_min)
    else $error("interrupt pulse too short");

  property p_nmi_len;
    @(posedge clock_i) disable iff (srst_i)
      $fell(nmi_o) |-> $past(nmi_cnt) == NW'(NMI_CYC - 1);
  endproperty
  a_nmi_len: assert property (p_nmi_len)
    else $error("interrupt pulse length wrong");

  property p_oneshot;
    @(posedge clock_i) disable iff (srst_i)
      (nmi_locked && !nmi_o && !rearm) |=> !$rose(nmi_o);
  endproperty
  a_oneshot: assert property (p_oneshot)
    else $error("second pulse without rearm");

  property p_chassis;
    @(posedge clock_i) disable iff (srst_i)
      (chassis_req_i && !nmi_locked && !nmi_o && !rearm) |=> $rose(nmi_o);
  endproperty
  a_chassis: assert property (p_chassis)
    else $error("chassis request did not pulse");

  property p_no_log;
    @(posedge clock_i) disable iff (srst_i)
      (!panel_button_i) |=> !panel_event_o;
  endproperty
  a_no_log: assert property (p_no_log)
    else $error("event logged without button");

  property p_panel;
    @(posedge clock_i) disable iff (srst_i)
      panel_button_i |=> panel_event_o;
  endproperty
  a_panel: assert property (p_panel)
    else $error("button event not logged");

  property p_wd_gate;
    @(posedge clock_i) disable iff (srst_i)
      (wd_pretimeout_i && !wd_action_diag_i && !chassis_req_i
       && !panel_button_i && !nmi_o) |=> !nmi_o;
  endproperty
  a_wd_gate: assert property (p_wd_gate)
    else $error("pulse from unconfigured pre-timeout");

  property p_adv;
    @(posedge clock_i) disable iff (srst_i)
      $rose(advanced_en_o) |-> $past(key_ack_i) && $past(key_probe_o);
  endproperty
  a_adv: assert property (p_adv)
    else $error("advanced enabled without key answer");
endmodule // dnb_diag

// ---- dv/dnb_host_model.sv ----
/*
  host side model: times each diagnostic interrupt pulse and plays the
  key module, answering a probe after a set delay when enabled.
  assumes all signals synchronous to clock_i.
*/
`timescale 1ns/100ps
module dnb_host_model (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  // from the block
  input  wire logic        nmi_i,
  input  wire logic        key_probe_i,
  // behaviour control
  input  wire logic        answer_en_i,
  input  wire logic [7:0]  ack_delay_i,
  // results
  output logic             key_ack_o,
  output logic [7:0]       pulse_cnt_o,
  output logic [31:0]      width_o
);
  logic [31:0] run;
  logic [7:0]  wait_cnt;
  logic        nmi_q;

  always_ff @(posedge clock_i) begin
    nmi_q    <= nmi_i;
    run      <= nmi_i ? run + 32'h1 : 32'h0;
    wait_cnt <= key_probe_i ? wait_cnt + 8'h1 : 8'h0;
    // an absent key never answers; idle acknowledge is low
    key_ack_o <= answer_en_i && key_probe_i && (wait_cnt >= ack_delay_i);
    if (nmi_q && !nmi_i) begin
      width_o <= run;
    end
    if (srst_i) begin
      pulse_cnt_o <= 8'h0;
    end else if (!nmi_q && nmi_i) begin
      pulse_cnt_o <= pulse_cnt_o + 8'h1;
    end
  end
endmodule // dnb_host_model

// ---- dv/dnb_diag_bench.sv ----
/*
  bench for the diagnostic interrupt and beep code block: key probe,
  the three pulse sources, lockout and rearm, event strobe, beep codes.
  assumes dnb_host_model as the host and key module.
*/
`timescale 1ns/100ps
module dnb_diag_bench;
  // slow clock figure keeps the interrupt pulse short in simulation
  localparam int CLKHZ   = 40000;
  localparam int NMI_CYC = CLKHZ / 1000;
  localparam int PTMO    = 16;
  logic        clock_i   = 1'b0;
  logic        srst_i    = 1'b1;
  logic [4:0]  req       = 5'h0;
  logic        wd_action = 1'b0;
  logic [5:0]  fail      = 6'h0;
  logic        answer_en = 1'b0;
  logic [7:0]  ack_delay = 8'h0;
  logic [15:0] on_t      = 16'h1;
  logic [15:0] gap_t     = 16'h1;
  logic [15:0] dgap_t    = 16'h5;
  logic        key_ack_i;
  logic        key_probe_o;
  logic        advanced_en_o;
  logic        nmi_o;
  logic        panel_event_o;
  logic        beep_o;
  logic        beep_busy_o;
  logic [7:0]  pulse_cnt;
  logic [31:0] width;
  logic [15:0] codes [6] = '{16'h1521, 16'h1524, 16'h1542,
                             16'h1544, 16'h1512, 16'h1514};
  int          failures = 0;
  int          checks   = 0;
  int          events   = 0;

  always #2.5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    if (panel_event_o === 1'b1) events++;
  end

  dnb_diag #(.CLK_HZ(CLKHZ), .NMI_MS(1), .TICK_DIV(4),
             .PROBE_TMO(PTMO)) dnb_diag_i (
    .clock_i, .srst_i, .chassis_req_i(req[0]), .panel_button_i(req[1]),
    .wd_pretimeout_i(req[2]), .wd_action_diag_i(wd_action),
    .sys_reset_i(req[3]), .power_down_i(req[4]), .no_cpu_i(fail[0]),
    .processor_model_identifier_bad_i(fail[1]),
    .pgood_dropout_i(fail[2]), .pgood_timeout_i(fail[3]),
    .voltage_regulator_wd_i(fail[4]), .psu_incompat_fail_i(fail[5]),
    .beep_on_t_i(on_t), .beep_gap_t_i(gap_t), .digit_gap_t_i(dgap_t),
    .key_ack_i, .key_probe_o, .advanced_en_o, .nmi_o, .panel_event_o,
    .beep_o, .beep_busy_o);

  dnb_host_model dnb_host_model_i (
    .clock_i, .srst_i, .nmi_i(nmi_o), .key_probe_i(key_probe_o),
    .answer_en_i(answer_en), .ack_delay_i(ack_delay),
    .key_ack_o(key_ack_i), .pulse_cnt_o(pulse_cnt), .width_o(width));

  task automatic note(input logic bad, input string m);
    checks++;
    if (bad !== 1'b0) begin
      failures++;
      $display("mismatch t=%0t %s", $time, m);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp, input string m);
    note(got !== exp, m);
  endtask
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp,
                       input string m);
    note(got !== exp, m);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic pulse(input int k);
    @(posedge clock_i);
    req[k] <= 1'b1;
    @(posedge clock_i);
    req[k] <= 1'b0;
  endtask
  task automatic wait_for(input logic v, input int n);
    for (int i = 0; i < n && nmi_o !== v; i++) @(posedge clock_i);
    cmp1(nmi_o, v, "nmi level");
  endtask
  // sel 0 watches the interrupt, sel 1 the beeper
  task automatic quiet(input int n, input bit sel, input string m);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge clock_i);
      seen = seen | (sel ? (beep_o | beep_busy_o) : nmi_o);
    end
    cmp1(seen, 1'b0, m);
  endtask

  task automatic t_probe(input logic ans, input logic [7:0] dly);
    @(posedge clock_i);
    answer_en <= ans;
    ack_delay <= dly;
    srst_i    <= 1'b1;
    tick(8);
    cmp1(advanced_en_o, 1'b0, "advanced in reset");
    srst_i <= 1'b0;
    tick(PTMO + 12);
    cmp1(advanced_en_o, ans, "advanced enable");
    cmp1(key_probe_o, 1'b0, "probe still on");
  endtask
  task automatic t_chassis();
    int e;
    e = events;
    pulse(0);
    wait_for(1'b1, 3);
    wait_for(1'b0, NMI_CYC + 5);
    tick(2);
    cmp1(width >= NMI_CYC, 1'b1, "nmi too short");
    cmp1(events == e, 1'b1, "chassis pulse logged");
    pulse(0);
    quiet(20, 0, "second pulse");
    pulse(3);
    tick(2);
  endtask
  task automatic t_panel();
    int e;
    e = events;
    pulse(1);
    wait_for(1'b1, 3);
    tick(2);
    cmp1(events == e + 1, 1'b1, "panel event");
    pulse(0);
    wait_for(1'b0, NMI_CYC + 5);
    tick(2);
    cmp1(width == NMI_CYC, 1'b1, "nmi width");
    pulse(0);
    quiet(20, 0, "pulse while locked");
    pulse(4);
    tick(2);
  endtask
  task automatic t_wd();
    int e;
    e = events;
    pulse(2);
    quiet(20, 0, "pretimeout without action");
    wd_action <= 1'b1;
    pulse(2);
    wait_for(1'b1, 3);
    tick(2);
    cmp1(events == e, 1'b1, "watchdog logged");
    cmp1(pulse_cnt == 8'h3, 1'b1, "pulse count");
    wait_for(1'b0, NMI_CYC + 5);
  endtask
  task automatic t_beep(input int k, input logic [15:0] exp);
    logic [15:0] got;
    int n;
    int low;
    got = 16'h0;
    n   = 0;
    low = 1;
    @(posedge clock_i);
    fail[k] <= 1'b1;
    for (int i = 0; i < 20 && beep_busy_o !== 1'b1; i++) tick(1);
    for (int i = 0; i < 2000 && beep_busy_o === 1'b1; i++) begin
      tick(1);
      if (beep_o === 1'b1 && low > 0) begin
        if (low > 16 && n > 0) begin
          got = {got[11:0], n[3:0]};
          n   = 0;
        end
        n++;
      end
      low = (beep_o === 1'b1) ? 0 : low + 1;
    end
    got = {got[11:0], n[3:0]};
    cmp16(got, exp, "beep code");
    quiet(300, 1, "beep repeated");
    fail[k] <= 1'b0;
    tick(3);
  endtask

  task automatic final_report();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock_i);
    failures++;
    final_report();
  end

  initial begin
    t_probe(1'b0, 8'h0);
    t_probe(1'b1, 8'h0);
    t_probe(1'b1, 8'h5);
    t_chassis();
    t_panel();
    t_wd();
    foreach (codes[k]) t_beep(k, codes[k]);
    t_beep(0, 16'h1521);
    final_report();
  end
endmodule // dnb_diag_bench
